// [core/line_alarm_pkg.sv]
// constants, register map and carrier types of the line alarm monitor
package line_alarm_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CONFIG = 8'h10;
	localparam logic [7:0] IDX_ENABLE = 8'h11;
	localparam logic [7:0] IDX_STATUS = 8'h12;
	localparam logic [7:0] IDX_ALT = 8'h13;

	// ==========================================================
	// field positions
	localparam int BIT_VIOL = 7;
	localparam int BIT_ABS_CHG = 6;
	localparam int BIT_SIG = 5;
	localparam int BIT_FOUR = 4;
	localparam int BIT_ABS = 0;
	localparam int BIT_ALT_EN = 7;
	localparam int BIT_ALT_CHG = 6;
	localparam int BIT_ALT = 0;
	localparam int BIT_MARK_INV = 7;
	localparam int BIT_THR_HI = 6;
	localparam int BIT_THR_LO = 5;
	localparam int BIT_COMPAT = 1;

	// ==========================================================
	// reset values and writable masks
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] CONFIG_WR_MASK = 8'hFE;
	localparam logic [3:0] ENABLE_RST = 4'h0;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic ALT_EN_RST = 1'b0;

	// ==========================================================
	// line timing counts, in bit periods
	localparam logic [7:0] THR_HDB3_BASE = 8'd10;
	localparam logic [7:0] THR_MARK_INV_BASE = 8'd15;
	localparam logic [7:0] THR_SEL_01 = 8'd31;
	localparam logic [7:0] THR_SEL_10 = 8'd63;
	localparam logic [7:0] THR_SEL_11 = 8'd175;
	localparam logic [7:0] ALT_QUIET_BITS = 8'd255;
	localparam logic [7:0] FOUR_ZERO_RUN = 8'd4;
	localparam logic [7:0] SIG_LEAD_SPACES = 8'd2;
	localparam logic [7:0] RUN_MAX = 8'hFF;

	// ==========================================================
	// carrier types
	typedef struct packed {
		logic mark_inv_only;
		logic thr_hi;
		logic thr_lo;
		logic test_compat;
	} line_cfg_t;

	// same order as status bits 7 down to 4
	typedef struct packed {
		logic violation;
		logic absent_change;
		logic signature;
		logic four_zero;
	} line_events_t;

endpackage

// [core/rail_sync.sv]
// two-flop synchroniser for the line pins, one chain per bit
`timescale 1ns/1ps
module rail_sync #(
	parameter int WIDTH = 3
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ==========================================================
	// per-bit chains; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_chain
			logic meta_reg;
			logic stable_reg;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta_reg <= 1'b0;
					stable_reg <= 1'b0;
				end else begin
					meta_reg <= async_in[i];
					stable_reg <= meta_reg;
				end
			end
			assign sync_out[i] = stable_reg;
		end
	endgenerate

endmodule

// [core/absent_detector.sv]
// space-run counter, signal-absent and alternate signal-absent status
`timescale 1ns/1ps
module absent_detector (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic bit_en,
	input wire logic mark,
	input wire line_alarm_pkg::line_cfg_t cfg,
	output logic [7:0] space_run,
	output logic four_zero,
	output logic absent,
	output logic alt_absent
);

	logic [7:0] run_reg;
	logic [7:0] run_next;
	logic [7:0] quiet_reg;
	logic [7:0] quiet_next;
	logic absent_reg;
	logic absent_next;
	logic alt_reg;
	logic alt_next;
	logic [7:0] threshold;

	// ==========================================================
	// threshold select
	always_comb begin
		unique case ({cfg.thr_hi, cfg.thr_lo})
			2'b00: threshold = cfg.mark_inv_only ? line_alarm_pkg::THR_MARK_INV_BASE
				: line_alarm_pkg::THR_HDB3_BASE;
			2'b01: threshold = line_alarm_pkg::THR_SEL_01;
			2'b10: threshold = line_alarm_pkg::THR_SEL_10;
			2'b11: threshold = line_alarm_pkg::THR_SEL_11;
		endcase
	end

	// ==========================================================
	// next values; the run saturates so long outages never wrap
	always_comb begin
		run_next = run_reg;
		quiet_next = quiet_reg;
		absent_next = absent_reg;
		alt_next = alt_reg;
		if (bit_en) begin
			if (mark) begin
				run_next = 8'h00;
			end else if (run_reg != line_alarm_pkg::RUN_MAX) begin
				run_next = run_reg + 8'd1;
			end
			// quiet span restarts while a four-space run is present
			if (!mark && run_next >= line_alarm_pkg::FOUR_ZERO_RUN) begin
				quiet_next = 8'h00;
			end else if (quiet_reg != line_alarm_pkg::ALT_QUIET_BITS) begin
				quiet_next = quiet_reg + 8'd1;
			end
			if (mark) begin
				absent_next = 1'b0;
			end else if (run_next > threshold) begin
				absent_next = 1'b1;
			end
			if (!mark && run_next > threshold) begin
				alt_next = 1'b1;
			end else if (alt_reg && quiet_next == line_alarm_pkg::ALT_QUIET_BITS) begin
				alt_next = 1'b0;
			end
		end
	end

	// ==========================================================
	// state registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_reg <= 8'h00;
			quiet_reg <= 8'h00;
			absent_reg <= 1'b0;
			alt_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			quiet_reg <= quiet_next;
			absent_reg <= absent_next;
			alt_reg <= alt_next;
		end
	end

	assign four_zero = bit_en && !mark && run_reg == line_alarm_pkg::FOUR_ZERO_RUN - 8'd1;
	assign space_run = run_reg;
	assign absent = absent_reg;
	assign alt_absent = alt_reg;

endmodule

// [core/line_code_alarm_monitor.sv]
// line code alarm monitor: rail checks, alarm status, AHB-Lite registers
// Contract
// - interrupt asserts when a pending event flag has its enable bit set.
// - reset clears the four event enable bits.
// - event flags latch on their event and hold until read or written with a one.
// - reading the status register clears all four event flags.
// - mark-inversion mode flags a violation on two same-polarity marks in a row.
// - HDB3, compat clear: violation if polarity repeats or not after two spaces.
// - HDB3, compat set: violation only if two successive violations share polarity.
// - signal-absent change flag sets on any toggle of the live status.
// - signature flag sets on opposite-polarity violation following two spaces.
// - four-zero flag sets on four consecutive spaces.
// - live signal-absent status sets when the space run exceeds the threshold.
// - live signal-absent status clears on a single mark.
// - alternate status sets when the zero run exceeds the same threshold.
// - alternate status clears after 255 bits without a four-zero run.
// - alternate change flag sets on any toggle; read of its register clears it.
// - alternate enable bit lets an alternate change raise the interrupt.
// - threshold is 10 or 15 by decoding mode, else 31, 63, 175.
// - mark-inversion mode disables decoding; otherwise signatures become four zeros.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module line_code_alarm_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rx_line_clock,
	input wire logic rx_positive_rail,
	input wire logic rx_negative_rail,
	output logic decoded_data,
	output logic decoded_valid,
	output logic interrupt_out_n
);

	// ==========================================================
	// pin synchronisation and bit strobe
	logic [2:0] pins_sync;
	logic clk_prev_reg;
	logic bit_en;
	logic pos_s;
	logic neg_s;
	logic mark;
	logic pol;

	rail_sync #(
		.WIDTH(3)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({rx_line_clock, rx_positive_rail, rx_negative_rail}),
		.sync_out(pins_sync)
	);

	// rising edge of the line clock marks one bit period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_prev_reg <= 1'b0;
		end else begin
			clk_prev_reg <= pins_sync[2];
		end
	end

	assign bit_en = pins_sync[2] && !clk_prev_reg;
	assign pos_s = pins_sync[1];
	assign neg_s = pins_sync[0];
	// both rails high is taken as a positive mark
	assign mark = pos_s || neg_s;
	assign pol = pos_s;

	// ==========================================================
	// register state
	logic [7:0] config_reg;
	logic [7:0] config_next;
	logic [3:0] enable_reg;
	logic [3:0] enable_next;
	logic [3:0] status_reg;
	logic [3:0] status_next;
	logic alt_en_reg;
	logic alt_en_next;
	logic alt_flag_reg;
	logic alt_flag_next;
	line_alarm_pkg::line_cfg_t cfg;

	assign cfg.mark_inv_only = config_reg[line_alarm_pkg::BIT_MARK_INV];
	assign cfg.thr_hi = config_reg[line_alarm_pkg::BIT_THR_HI];
	assign cfg.thr_lo = config_reg[line_alarm_pkg::BIT_THR_LO];
	assign cfg.test_compat = config_reg[line_alarm_pkg::BIT_COMPAT];

	// ==========================================================
	// signal-absent detection
	logic [7:0] space_run;
	logic four_zero;
	logic absent;
	logic alt_absent;
	logic absent_q_reg;
	logic alt_q_reg;

	absent_detector u_absent (
		.hclk(hclk),
		.hresetn(hresetn),
		.bit_en(bit_en),
		.mark(mark),
		.cfg(cfg),
		.space_run(space_run),
		.four_zero(four_zero),
		.absent(absent),
		.alt_absent(alt_absent)
	);

	// ==========================================================
	// bipolar violation tracking
	logic mark_seen_reg;
	logic last_mark_pol_reg;
	logic bpv_seen_reg;
	logic last_bpv_pol_reg;
	logic mark_seen_next;
	logic last_mark_pol_next;
	logic bpv_seen_next;
	logic last_bpv_pol_next;
	logic bpv;
	logic two_spaces;
	logic bpv_repeat;
	line_alarm_pkg::line_events_t ev;

	always_comb begin
		bpv = bit_en && mark && mark_seen_reg && pol == last_mark_pol_reg;
		two_spaces = space_run >= line_alarm_pkg::SIG_LEAD_SPACES;
		bpv_repeat = bpv_seen_reg && pol == last_bpv_pol_reg;
		ev.signature = bpv && two_spaces && !bpv_repeat;
		if (cfg.mark_inv_only) begin
			ev.violation = bpv;
		end else if (cfg.test_compat) begin
			ev.violation = bpv && bpv_repeat;
		end else begin
			ev.violation = bpv && (bpv_repeat || !two_spaces);
		end
		ev.four_zero = four_zero;
		ev.absent_change = absent != absent_q_reg;
		mark_seen_next = mark_seen_reg;
		last_mark_pol_next = last_mark_pol_reg;
		bpv_seen_next = bpv_seen_reg;
		last_bpv_pol_next = last_bpv_pol_reg;
		if (bit_en && mark) begin
			mark_seen_next = 1'b1;
			last_mark_pol_next = pol;
		end
		if (bpv) begin
			bpv_seen_next = 1'b1;
			last_bpv_pol_next = pol;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mark_seen_reg <= 1'b0;
			last_mark_pol_reg <= 1'b0;
			bpv_seen_reg <= 1'b0;
			last_bpv_pol_reg <= 1'b0;
			absent_q_reg <= 1'b0;
			alt_q_reg <= 1'b0;
		end else begin
			mark_seen_reg <= mark_seen_next;
			last_mark_pol_reg <= last_mark_pol_next;
			bpv_seen_reg <= bpv_seen_next;
			last_bpv_pol_reg <= last_bpv_pol_next;
			absent_q_reg <= absent;
			alt_q_reg <= alt_absent;
		end
	end

	// ==========================================================
	// decoded output: four-bit delay so a signature can be blanked
	logic [3:0] pipe_reg;
	logic [3:0] pipe_next;
	logic decoded_data_next;
	logic decoded_valid_next;

	always_comb begin
		pipe_next = pipe_reg;
		decoded_data_next = decoded_data;
		decoded_valid_next = bit_en;
		if (bit_en) begin
			decoded_data_next = pipe_reg[3];
			if (ev.signature && !cfg.mark_inv_only) begin
				pipe_next = 4'h0;
			end else begin
				pipe_next = {pipe_reg[2:0], mark};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pipe_reg <= 4'h0;
			decoded_data <= 1'b0;
			decoded_valid <= 1'b0;
		end else begin
			pipe_reg <= pipe_next;
			decoded_data <= decoded_data_next;
			decoded_valid <= decoded_valid_next;
		end
	end

	// ==========================================================
	// AHB-Lite slave: zero wait, read data captured in address phase
	logic accept;
	logic mapped;
	logic [7:0] idx;
	logic rd_status;
	logic rd_alt;
	logic wr_pend_reg;
	logic [7:0] wr_idx_reg;
	logic [31:0] rdata_next;

	assign accept = hsel && hready && htrans[1];
	assign mapped = haddr[31:10] == 22'h000000 && haddr[1:0] == 2'b00;
	assign idx = haddr[9:2];
	// read side effects fire when the read is committed
	assign rd_status = accept && !hwrite && mapped && idx == line_alarm_pkg::IDX_STATUS;
	assign rd_alt = accept && !hwrite && mapped && idx == line_alarm_pkg::IDX_ALT;

	always_comb begin
		rdata_next = hrdata;
		if (accept && !hwrite) begin
			rdata_next = 32'h0000_0000; // unmapped reads zero
			if (mapped) begin
				unique case (idx)
					line_alarm_pkg::IDX_CONFIG: rdata_next[7:0] = config_reg;
					line_alarm_pkg::IDX_ENABLE: rdata_next[7:4] = enable_reg;
					line_alarm_pkg::IDX_STATUS: begin
						rdata_next[7:4] = status_reg;
						rdata_next[line_alarm_pkg::BIT_ABS] = absent;
					end
					line_alarm_pkg::IDX_ALT: begin
						rdata_next[line_alarm_pkg::BIT_ALT_EN] = alt_en_reg;
						rdata_next[line_alarm_pkg::BIT_ALT_CHG] = alt_flag_reg;
						rdata_next[line_alarm_pkg::BIT_ALT] = alt_absent;
					end
					default: rdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// register next values; a new event wins over a clear
	always_comb begin
		config_next = config_reg;
		enable_next = enable_reg;
		alt_en_next = alt_en_reg;
		status_next = status_reg;
		alt_flag_next = alt_flag_reg;
		if (rd_status) begin
			status_next = 4'h0;
		end
		if (rd_alt) begin
			alt_flag_next = 1'b0;
		end
		if (wr_pend_reg) begin
			unique case (wr_idx_reg)
				line_alarm_pkg::IDX_CONFIG: config_next = hwdata[7:0] & line_alarm_pkg::CONFIG_WR_MASK;
				line_alarm_pkg::IDX_ENABLE: enable_next = hwdata[7:4];
				line_alarm_pkg::IDX_STATUS: status_next = status_next & ~hwdata[7:4];
				line_alarm_pkg::IDX_ALT: begin
					alt_en_next = hwdata[line_alarm_pkg::BIT_ALT_EN];
					alt_flag_next = alt_flag_next & ~hwdata[line_alarm_pkg::BIT_ALT_CHG];
				end
				default: config_next = config_reg;
			endcase
		end
		status_next = status_next | ev;
		if (alt_absent != alt_q_reg) begin
			alt_flag_next = 1'b1;
		end
	end

	// interrupt level from enabled sticky flags, registered
	logic irq_any;
	assign irq_any = |(status_reg & enable_reg) || (alt_flag_reg && alt_en_reg);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_reg <= line_alarm_pkg::CONFIG_RST;
			enable_reg <= line_alarm_pkg::ENABLE_RST;
			status_reg <= line_alarm_pkg::STATUS_RST;
			alt_en_reg <= line_alarm_pkg::ALT_EN_RST;
			alt_flag_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else begin
			config_reg <= config_next;
			enable_reg <= enable_next;
			status_reg <= status_next;
			alt_en_reg <= alt_en_next;
			alt_flag_reg <= alt_flag_next;
			wr_pend_reg <= accept && hwrite && mapped;
			wr_idx_reg <= idx;
			hrdata <= rdata_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			interrupt_out_n <= !irq_any;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_irq_on_enabled: assert property (|(status_reg & enable_reg) |=> !interrupt_out_n)
		else $error("enabled event flag did not assert interrupt");
	a_irq_quiet_disabled: assert property (enable_reg == 4'h0 && !alt_en_reg |=> interrupt_out_n)
		else $error("interrupt asserted with all enables clear");
	a_flag_holds: assert property (status_reg[3] && !rd_status && !(wr_pend_reg
		&& wr_idx_reg == line_alarm_pkg::IDX_STATUS) |=> status_reg[3])
		else $error("violation flag dropped without a read");
	a_read_clears: assert property (rd_status && ev == 4'h0 |=> status_reg == 4'h0)
		else $error("status read did not clear event flags");
	a_mark_inv_viol: assert property (cfg.mark_inv_only && bpv |=> status_reg[3])
		else $error("same-polarity marks not flagged");
	a_compat_viol: assert property (!cfg.mark_inv_only && cfg.test_compat && bpv
		&& bpv_repeat |=> status_reg[3])
		else $error("repeated violation polarity not flagged");
	a_strict_viol: assert property (!cfg.mark_inv_only && !cfg.test_compat && bpv
		&& !two_spaces |=> status_reg[3])
		else $error("violation without two spaces not flagged");
	a_signature_flag: assert property (ev.signature |=> status_reg[1])
		else $error("signature not flagged");
	a_four_zero_flag: assert property (four_zero |=> status_reg[0] ##1 status_reg[0] || $past(rd_status))
		else $error("four-zero event not flagged");
	a_absent_mark_clear: assert property (bit_en && mark |=> !absent)
		else $error("signal-absent did not clear on a mark");
	a_absent_toggle: assert property (absent != absent_q_reg |=> status_reg[2])
		else $error("signal-absent change not flagged");
	a_alt_toggle: assert property (alt_absent != alt_q_reg |=> alt_flag_reg)
		else $error("alternate change not flagged");
	a_alt_irq: assert property (alt_flag_reg && alt_en_reg |=> !interrupt_out_n)
		else $error("alternate change did not interrupt");

	c_signature: cover property (ev.signature && !cfg.mark_inv_only);
	c_absent_rise: cover property ($rose(absent));
	c_alt_fall: cover property ($fell(alt_absent));
	c_irq_cycle: cover property ($fell(interrupt_out_n) ##[1:1000] $rose(interrupt_out_n));

endmodule

// [tb/line_rail_driver.sv]
// behavioural model of the bipolar receive line feeding the monitor
`timescale 1ns/1ps
module line_rail_driver (
	input wire logic hclk,
	output logic line_clk,
	output logic pos_rail,
	output logic neg_rail
);
	// ==========================================================
	// idle line: clock low, both rails at space
	initial begin
		line_clk = 1'b0;
		pos_rail = 1'b0;
		neg_rail = 1'b0;
	end

	// ==========================================================
	// one bit period: rails settle 4 hclk before the rising edge
	// rails set well ahead because the pins pass a two-flop synchroniser
	task automatic send_bit(input logic p, input logic n);
		@(posedge hclk);
		pos_rail <= p;
		neg_rail <= n;
		repeat (4) @(posedge hclk);
		line_clk <= 1'b1;
		repeat (5) @(posedge hclk);
		line_clk <= 1'b0;
		repeat (5) @(posedge hclk);
	endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench of the line code alarm monitor
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic line_clk;
	logic pos_rail;
	logic neg_rail;
	logic interrupt_out_n;
	logic decoded_data;
	logic decoded_valid;
	logic last_p = 1'b0;
	int dec_ones = 0;
	int dec_bits = 0;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;

	// ==========================================================
	// clock, reset and hang guard
	always #25 hclk = ~hclk;

	// ceiling well above the longest run of bit periods used below
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// ==========================================================
	// design and line model
	line_code_alarm_monitor u_line_code_alarm_monitor (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rx_line_clock(line_clk), .rx_positive_rail(pos_rail), .rx_negative_rail(neg_rail),
		.decoded_data(decoded_data), .decoded_valid(decoded_valid), .interrupt_out_n(interrupt_out_n)
	);

	// decoded stream tally; old values at the edge are the ones that stood
	always @(posedge hclk) begin
		if (decoded_valid === 1'b1) begin
			dec_bits <= dec_bits + 1;
			if (decoded_data === 1'b1) begin
				dec_ones <= dec_ones + 1;
			end
		end
	end

	line_rail_driver u_line_rail_driver (
		.hclk(hclk), .line_clk(line_clk), .pos_rail(pos_rail), .neg_rail(neg_rail)
	);

	// ==========================================================
	// shared helpers
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// single AHB-Lite transfer, address phase held until hready seen high
	task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("hresp", 8'h00, {7'h00, hresp});
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		bus_xfer(idx, 1'b1, {24'h000000, d}, r);
	endtask

	// read a register and compare the masked low byte
	task automatic reg_chk(input string name, input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
		logic [31:0] r;
		bus_xfer(idx, 1'b0, 32'h0000_0000, r);
		check(name, exp, r[7:0] & mask);
	endtask

	// interrupt pin settles two cycles after its cause
	task automatic int_chk(input logic exp);
		repeat (3) @(posedge hclk);
		check("interrupt_out_n", {7'h00, exp}, {7'h00, interrupt_out_n});
	endtask

	task automatic mark(input logic p);
		u_line_rail_driver.send_bit(p, ~p);
		last_p = p;
	endtask

	task automatic marks(input int n);
		repeat (n) mark(~last_p);
	endtask

	task automatic spaces(input int n);
		repeat (n) u_line_rail_driver.send_bit(1'b0, 1'b0);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		int_chk(1'b1);
		reg_chk("enable", line_alarm_pkg::IDX_ENABLE, 8'hF0, 8'h00);
		reg_chk("status", line_alarm_pkg::IDX_STATUS, 8'hF0, 8'h00);
		reg_chk("alt", line_alarm_pkg::IDX_ALT, 8'h80, 8'h00);
		reg_chk("config", line_alarm_pkg::IDX_CONFIG, 8'hFF, 8'h00);
		reg_chk("unmapped", 8'h20, 8'hFF, 8'h00);
	endtask

	// decoding on: P N 0 0 N is a signature, then P P is a bare violation
	task automatic t_signature();
		int base_ones;
		int base_bits;
		base_ones = dec_ones;
		base_bits = dec_bits;
		mark(1'b1);
		mark(1'b0);
		spaces(2);
		mark(1'b0);
		reg_chk("sig", line_alarm_pkg::IDX_STATUS, 8'hA0, 8'h20);
		mark(1'b1);
		mark(1'b1);
		// seven bits out; N 0 0 N blanked, only the leading P has emerged
		check("decoded_bits", 8'h07, 8'(dec_bits - base_bits));
		check("decoded_ones", 8'h01, 8'(dec_ones - base_ones));
		reg_chk("viol", line_alarm_pkg::IDX_STATUS, 8'hA0, 8'h80);
		reg_chk("cleared", line_alarm_pkg::IDX_STATUS, 8'hF0, 8'h00);
	endtask

	// compat set: only a repeated violation polarity counts
	task automatic t_compat();
		reg_wr(line_alarm_pkg::IDX_CONFIG, 8'h02);
		mark(1'b0);
		mark(1'b0);
		reg_chk("viol_opp", line_alarm_pkg::IDX_STATUS, 8'h80, 8'h00);
		mark(1'b0);
		reg_chk("viol_same", line_alarm_pkg::IDX_STATUS, 8'h80, 8'h80);
	endtask

	// decoding off: same rail twice in a row
	task automatic t_mark_inv();
		reg_wr(line_alarm_pkg::IDX_CONFIG, 8'h80);
		mark(1'b1);
		mark(1'b0);
		reg_chk("ami_alt", line_alarm_pkg::IDX_STATUS, 8'h80, 8'h00);
		mark(1'b1);
		mark(1'b1);
		reg_chk("ami_viol", line_alarm_pkg::IDX_STATUS, 8'h80, 8'h80);
		reg_wr(line_alarm_pkg::IDX_CONFIG, 8'h00);
	endtask

	task automatic t_four_zero();
		reg_wr(line_alarm_pkg::IDX_ENABLE, 8'h10);
		reg_chk("enable_rw", line_alarm_pkg::IDX_ENABLE, 8'hF0, 8'h10);
		spaces(3);
		int_chk(1'b1);
		spaces(1);
		int_chk(1'b0);
		reg_chk("four_zero", line_alarm_pkg::IDX_STATUS, 8'h10, 8'h10);
		int_chk(1'b1);
		reg_chk("four_zero_clr", line_alarm_pkg::IDX_STATUS, 8'h10, 8'h00);
		reg_wr(line_alarm_pkg::IDX_ENABLE, 8'h00);
	endtask

	// threshold 10 with decoding on; alternate status needs 255 quiet bits
	task automatic t_absent();
		mark(~last_p);
		reg_chk("pre", line_alarm_pkg::IDX_STATUS, 8'hF0, 8'h00);
		reg_wr(line_alarm_pkg::IDX_ALT, 8'h80);
		spaces(10);
		reg_chk("abs_at_thr", line_alarm_pkg::IDX_STATUS, 8'h01, 8'h00);
		int_chk(1'b1);
		spaces(1);
		reg_chk("abs_set", line_alarm_pkg::IDX_STATUS, 8'h41, 8'h41);
		int_chk(1'b0);
		reg_chk("alt_set", line_alarm_pkg::IDX_ALT, 8'hC1, 8'hC1);
		int_chk(1'b1);
		mark(~last_p);
		reg_chk("abs_clr", line_alarm_pkg::IDX_STATUS, 8'h41, 8'h40);
		// 254 quiet bits so far: one short of the clearing span
		marks(253);
		reg_chk("alt_held", line_alarm_pkg::IDX_ALT, 8'h41, 8'h01);
		marks(1);
		reg_chk("alt_clr", line_alarm_pkg::IDX_ALT, 8'h41, 8'h40);
		reg_chk("alt_flag_clr", line_alarm_pkg::IDX_ALT, 8'h40, 8'h00);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_signature();
		t_compat();
		t_mark_inv();
		t_four_zero();
		t_absent();
		end_of_test();
	end
endmodule
